// [src/ssbr_baud_gen.sv]
// Purpose: Baud generator giving a 16x oversampling tick
// Assumes: Prescaler divides mclk by 1, 4, 16 or 64 per clock select
// Notes: Tick rate is mclk / (prescale * (divisor + 1))
`timescale 1ns/1ps
module ssbr_baud_gen (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Settings
  input wire logic [1:0] clockSelect,
  input wire logic [7:0] divisor,
  // Tick out
  output logic tick
);
  import ssbr_pkg::*;

  typedef struct packed {
    logic [5:0] prescale;
    logic [7:0] count;
    logic tick;
  } ssbr_baud_type;

  ssbr_baud_type s;
  ssbr_baud_type next_s;
  logic [5:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    unique case (clockSelect)
      2'h0: limit = 6'h00;
      2'h1: limit = 6'h03;
      2'h2: limit = 6'h0f;
      default: limit = 6'h3f;
    endcase
    if (s.prescale >= limit) begin
      next_s.prescale = 6'h00;
      if (s.count == 8'h00) begin
        next_s.count = divisor;
        next_s.tick = 1'b1;
      end else begin
        next_s.count = s.count - 8'h01;
      end
    end else begin
      next_s.prescale = s.prescale + 6'h01;
    end
    if (!rstn) begin
      next_s = '{prescale: 6'h00, count: DIVISOR_RESET, tick: 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  assign tick = s.tick;

endmodule

// [src/ssbr_core.sv]
// Purpose: Serial status flags, bit rate divisor and a compact async shifter
// Assumes: APB slave, rxd synchronous to mclk, standby is a level input
// Notes: Flags clear only after a read that saw them set
//
// Operation
// - Status resets and enters standby as 84
// - Write zero clears flags; write one ignored
// - Tx empty sets on load or disable
// - Clear needs prior read of set flag
// - Rx full sets on good character moved
// - Overrun sets when rx full already
// - Framing error on stop bit zero, async
// - Parity error on mismatch, async with parity
// - Tx end sets, stops when buffer empty
// - Tx end sets on disable, read only
// - Clearing tx empty also clears tx end
// - Rx multiproc bit captured, read only
// - Rx multiproc bit holds when not applicable
// - Tx multiproc bit double buffered, sent
// - Divisor and clock select set rate
// - Divisor resets and enters standby as ff
// - Tx end irq when enabled and set
// - Multiproc filter drops characters with bit zero
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module ssbr_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Power
  input wire logic standby,
  // Serial line
  input wire logic rxd,
  output logic txd,
  output logic txdOe,
  // Interrupt request
  output logic txEndIrq
);
  import ssbr_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] mode;
    logic [7:0] control;
    logic [7:0] divisor;
    logic [7:0] txData;
    logic [7:0] rxData;
    logic [4:0] flags;
    logic [4:0] armed;
    logic txEnd;
    logic rxMpb;
    logic txMpb;
    ssbr_tx_type txState;
    logic [10:0] txFrame;
    logic [3:0] txBits;
    logic [3:0] txTicks;
    ssbr_rx_type rxState;
    logic [3:0] rxTicks;
    logic [3:0] rxIndex;
    logic [8:0] rxShift;
    logic txd;
    logic txdOe;
    logic txEndIrq;
  } ssbr_state_type;

  localparam ssbr_state_type RESET_STATE = '{
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
    mode: MODE_RESET, control: CONTROL_RESET, divisor: DIVISOR_RESET,
    txData: 8'h00, rxData: 8'h00,
    flags: STATUS_RESET[7:3], armed: 5'h00,
    txEnd: STATUS_RESET[ST_TX_END], rxMpb: STATUS_RESET[ST_RX_MPB], txMpb: STATUS_RESET[ST_TX_MPB],
    txState: SSBR_TX_IDLE, txFrame: 11'h7ff, txBits: 4'h0, txTicks: 4'h0,
    rxState: SSBR_RX_IDLE, rxTicks: 4'h0, rxIndex: 4'h0, rxShift: 9'h000,
    txd: 1'b1, txdOe: 1'b0, txEndIrq: 1'b0
  };

  ssbr_state_type s;
  ssbr_state_type next_s;
  logic tick;
  logic access;
  logic done;
  logic wr;
  logic [7:0] statusValue;
  logic [31:0] readValue;
  logic readError;
  logic hasExtra;
  logic extraBit;
  logic [3:0] lastIndex;
  logic rxMpbit;
  logic expectParity;
  logic frameErr;
  logic parityErr;
  logic dropChar;

  ////////////////////////////////////////////////////////////////////////////
  // Bit rate generator
  ssbr_baud_gen baudGen (
    .mclk(mclk),
    .rstn(rstn),
    .clockSelect({s.mode[MD_CLOCK_SELECT_HI], s.mode[MD_CLOCK_SELECT_LO]}),
    .divisor(s.divisor),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame builder: start, 8 data bits, optional parity or multiproc bit, stop
  function automatic logic [14:0] buildFrame(input logic [7:0] data, input logic rx_multiproc_bit, input logic [7:0] mode);
    logic [10:0] frame;
    logic [3:0] bits;
    frame = {2'b11, data, 1'b0};
    bits = FRAME_BITS_BASE;
    if (mode[MD_PARITY_EN]) begin
      frame[9] = (^data) ^ mode[MD_ODD];
      bits = FRAME_BITS_BASE + 4'h1;
    end else if (mode[MD_MULTIPROC] && !mode[MD_SYNC]) begin
      frame[9] = rx_multiproc_bit;
      bits = FRAME_BITS_BASE + 4'h1;
    end
    buildFrame = {bits, frame};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    access = psel && penable;
    done = access && s.pready;
    wr = done && pwrite;
    hasExtra = s.mode[MD_PARITY_EN] || (s.mode[MD_MULTIPROC] && !s.mode[MD_SYNC]);
    extraBit = 1'b0;
    lastIndex = hasExtra ? 4'ha : 4'h9;
    rxMpbit = s.rxShift[8];
    expectParity = (^s.rxShift[7:0]) ^ s.mode[MD_ODD];
    frameErr = 1'b0;
    parityErr = 1'b0;
    dropChar = 1'b0;
    statusValue = {s.flags, s.txEnd, s.rxMpb, s.txMpb};
    readError = 1'b0;
    unique case (paddr)
      OFS_MODE: readValue = {24'h000000, s.mode};
      OFS_DIVISOR: readValue = {24'h000000, s.divisor};
      OFS_CONTROL: readValue = {24'h000000, s.control};
      OFS_TXDATA: readValue = {24'h000000, s.txData};
      OFS_STATUS: readValue = {24'h000000, statusValue};
      OFS_RXDATA: readValue = {24'h000000, s.rxData};
      default: begin
        readValue = 32'h0000_0000;
        readError = 1'b1;
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // APB: one wait state, answer registered
    next_s.pready = access && !s.pready;
    if (access && !s.pready) begin
      next_s.pslverr = readError;
      next_s.prdata = pwrite ? 32'h0000_0000 : readValue;
      if (!pwrite && paddr == OFS_STATUS) begin
        next_s.armed = s.armed | s.flags;
      end
    end else begin
      next_s.pslverr = 1'b0;
    end

    if (wr && !readError) begin
      unique case (paddr)
        OFS_MODE: next_s.mode = pwdata[7:0];
        OFS_DIVISOR: next_s.divisor = pwdata[7:0];
        OFS_CONTROL: next_s.control = pwdata[7:0];
        OFS_TXDATA: next_s.txData = pwdata[7:0];
        OFS_STATUS: begin
          for (int i = 0; i < 5; i++) begin
            if (!pwdata[ST_CLEAR_LOW + i] && s.armed[i]) begin
              next_s.flags[i] = 1'b0;
              next_s.armed[i] = 1'b0;
            end
          end
          if (!pwdata[ST_TX_EMPTY] && s.armed[FL_TX_EMPTY]) begin
            next_s.txEnd = 1'b0;
          end
          next_s.txMpb = pwdata[ST_TX_MPB];
        end
        default: next_s.mode = s.mode;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmitter
    if (!s.control[CT_TRANSMIT_ENABLE]) begin
      next_s.txState = SSBR_TX_IDLE;
      next_s.flags[FL_TX_EMPTY] = 1'b1;
      next_s.txEnd = 1'b1;
      next_s.txFrame = 11'h7ff;
    end else begin
      unique case (s.txState)
        SSBR_TX_IDLE: begin
          if (!s.flags[FL_TX_EMPTY]) begin
            {next_s.txBits, next_s.txFrame} = buildFrame(s.txData, s.txMpb, s.mode);
            next_s.txTicks = 4'h0;
            next_s.txState = SSBR_TX_SHIFT;
            next_s.flags[FL_TX_EMPTY] = 1'b1;
            next_s.armed[FL_TX_EMPTY] = 1'b0;
          end
        end
        SSBR_TX_SHIFT: begin
          if (tick) begin
            next_s.txTicks = s.txTicks + 4'h1;
            if (s.txTicks == TICK_LAST) begin
              next_s.txFrame = {1'b1, s.txFrame[10:1]};
              next_s.txBits = s.txBits - 4'h1;
              if (s.txBits == 4'h1) begin
                if (s.flags[FL_TX_EMPTY]) begin
                  next_s.txEnd = 1'b1;
                  next_s.txState = SSBR_TX_IDLE;
                end else begin
                  {next_s.txBits, next_s.txFrame} = buildFrame(s.txData, s.txMpb, s.mode);
                  next_s.flags[FL_TX_EMPTY] = 1'b1;
                  next_s.armed[FL_TX_EMPTY] = 1'b0;
                end
              end
            end
          end
        end
      endcase
    end
    next_s.txd = (s.txState == SSBR_TX_SHIFT) ? s.txFrame[0] : 1'b1;
    next_s.txdOe = s.control[CT_TRANSMIT_ENABLE];
    next_s.txEndIrq = s.control[CT_TX_END_IRQ_ENABLE] && s.txEnd;

    //////////////////////////////////////////////////////////////////////////
    // Receiver
    if (!s.control[CT_RECEIVE_ENABLE]) begin
      next_s.rxState = SSBR_RX_IDLE;
    end else begin
      unique case (s.rxState)
        SSBR_RX_IDLE: begin
          if (tick && !rxd) begin
            next_s.rxState = SSBR_RX_SHIFT;
            next_s.rxTicks = 4'h0;
            next_s.rxIndex = 4'h0;
          end
        end
        SSBR_RX_SHIFT: begin
          if (tick) begin
            next_s.rxTicks = s.rxTicks + 4'h1;
            if (s.rxTicks == SAMPLE_TICK) begin
              next_s.rxIndex = s.rxIndex + 4'h1;
              if (s.rxIndex == 4'h0) begin
                if (rxd) begin
                  next_s.rxState = SSBR_RX_IDLE;
                end
              end else if (s.rxIndex < lastIndex) begin
                next_s.rxShift[s.rxIndex - 4'h1] = rxd;
              end else begin
                next_s.rxState = SSBR_RX_IDLE;
                if (!hasExtra) begin
                  rxMpbit = 1'b0;
                end
                extraBit = s.mode[MD_MULTIPROC] && !s.mode[MD_SYNC] && !s.mode[MD_PARITY_EN];
                dropChar = extraBit && s.control[CT_MULTIPROC_IRQ_ENABLE] && !rxMpbit;
                frameErr = !rxd && !s.mode[MD_SYNC];
                parityErr = s.mode[MD_PARITY_EN] && !s.mode[MD_SYNC] && (s.rxShift[8] != expectParity);
                if (!dropChar) begin
                  if (extraBit) begin
                    next_s.rxMpb = rxMpbit;
                    if (rxMpbit) begin
                      next_s.control[CT_MULTIPROC_IRQ_ENABLE] = 1'b0;
                    end
                  end
                  if (s.flags[FL_RX_FULL]) begin
                    next_s.flags[FL_OVERRUN] = 1'b1;
                  end else begin
                    if (frameErr) begin
                      next_s.flags[FL_FRAMING] = 1'b1;
                    end
                    if (parityErr) begin
                      next_s.flags[FL_PARITY] = 1'b1;
                    end
                    if (!frameErr && !parityErr) begin
                      next_s.rxData = s.rxShift[7:0];
                      next_s.flags[FL_RX_FULL] = 1'b1;
                    end
                  end
                end
              end
            end
          end
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Standby and reset
    if (standby) begin
      {next_s.flags, next_s.txEnd, next_s.rxMpb, next_s.txMpb} = STATUS_RESET;
      next_s.armed = 5'h00;
      next_s.divisor = DIVISOR_RESET;
      next_s.txState = SSBR_TX_IDLE;
      next_s.rxState = SSBR_RX_IDLE;
    end
    if (!rstn) begin
      next_s = RESET_STATE;
    end
  end

  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign txd = s.txd;
  assign txdOe = s.txdOe;
  assign txEndIrq = s.txEndIrq;

endmodule

// [src/ssbr_pkg.sv]
// Purpose: Shared constants and types of the serial status and bit rate block
// Assumes: 32-bit APB, one register per aligned word
// Notes: Offsets are byte addresses inside a 4 KiB window
package ssbr_pkg;

  // Register offsets
  localparam logic [11:0] OFS_MODE = 12'h000;
  localparam logic [11:0] OFS_DIVISOR = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;
  localparam logic [11:0] OFS_TXDATA = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_RXDATA = 12'h014;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h84;
  localparam logic [7:0] DIVISOR_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Status fields
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 4;
  localparam int ST_PARITY = 3;
  localparam int ST_TX_END = 2;
  localparam int ST_RX_MPB = 1;
  localparam int ST_TX_MPB = 0;
  localparam int ST_CLEAR_LOW = 3;

  // Clearable flag indices, status bit minus ST_CLEAR_LOW
  localparam int FL_TX_EMPTY = 4;
  localparam int FL_RX_FULL = 3;
  localparam int FL_OVERRUN = 2;
  localparam int FL_FRAMING = 1;
  localparam int FL_PARITY = 0;

  // Mode fields
  localparam int MD_SYNC = 7;
  localparam int MD_PARITY_EN = 5;
  localparam int MD_ODD = 4;
  localparam int MD_MULTIPROC = 2;
  localparam int MD_CLOCK_SELECT_HI = 1;
  localparam int MD_CLOCK_SELECT_LO = 0;

  // Control fields
  localparam int CT_TRANSMIT_ENABLE = 5;
  localparam int CT_RECEIVE_ENABLE = 4;
  localparam int CT_MULTIPROC_IRQ_ENABLE = 3;
  localparam int CT_TX_END_IRQ_ENABLE = 2;

  // Bit timing
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_TICK = 4'h7;
  localparam logic [3:0] FRAME_BITS_BASE = 4'ha;

  typedef enum logic {SSBR_TX_IDLE, SSBR_TX_SHIFT} ssbr_tx_type;
  typedef enum logic {SSBR_RX_IDLE, SSBR_RX_SHIFT} ssbr_rx_type;

endpackage

// [verification/ssbr_core_props.sv]
// Purpose: Port-level checks of the serial status and bit rate core
// Assumes: Divisor 0 or larger, one wait state per APB access
// Notes: Bound into ssbr_core
`timescale 1ns/1ps
module ssbr_core_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Power and serial line
  input wire logic standby,
  input wire logic rxd,
  input wire logic txd,
  input wire logic txdOe,
  input wire logic txEndIrq
);
  import ssbr_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  sequence acc_s;
    psel && penable && !pready;
  endsequence
  sequence rd_s(logic [11:0] a);
    psel && penable && !pready && !pwrite && paddr == a;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  wait_state_a: assert property (acc_s |=> pready)
    else $error("access not answered after one wait");
  reset_idle_a: assert property ($rose(rstn) |-> txd && !txdOe && !txEndIrq && !pready)
    else $error("outputs not idle after reset");
  standby_status_a: assert property (standby[*2] ##0 rd_s(OFS_STATUS) |=> prdata == 32'h84)
    else $error("status not reset in standby");
  standby_divisor_a: assert property (standby[*2] ##0 rd_s(OFS_DIVISOR) |=> prdata == 32'hff)
    else $error("divisor not reset in standby");
  tx_off_idle_a: assert property ((!txdOe)[*2] |-> txd)
    else $error("txd active while transmit disabled");
  start_bit_a: assert property ($fell(txd) |-> (!txd)[*8] ##8 !txd)
    else $error("serial bit shorter than sixteen ticks");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule
bind ssbr_core ssbr_core_props ssbr_core_props_inst (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .standby(standby), .rxd(rxd), .txd(txd), .txdOe(txdOe), .txEndIrq(txEndIrq));

// [verification/ssbr_core_test.sv]
// Purpose: Self-checking bench of the serial status and bit rate core
// Assumes: Divisor 0, clock select 0 during serial traffic
// Notes: Expected status values follow the flag rules
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("Error at %0t got %h exp %h", $time, g, e); end end
`define RDC(a, e) begin xfer(1'b0, a, 32'h0); `CHK(rv, e) end
module ssbr_core_test;
  import ssbr_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic standby = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, txd, txdOe, txEndIrq, rxd, slv;
  logic [7:0] d, c;
  int fails = 0;
  int cmp_count = 0;
  int n;
  always #4 mclk = ~mclk;
  ssbr_core ssbr_core_inst (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
    .rxd(rxd), .txd(txd), .txdOe(txdOe), .txEndIrq(txEndIrq));
  ssbr_peer ssbr_peer_inst (.mclk(mclk), .txd(txd), .txdOe(txdOe), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask
  task complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h772e8ff3));
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    `RDC(OFS_STATUS, 32'h84)
    `RDC(OFS_DIVISOR, 32'hff)
    `RDC(12'h018, 32'h0)
    `CHK(slv, 1'b1)
    d = 8'($urandom);
    wr(OFS_DIVISOR, {24'h0, d});
    `RDC(OFS_DIVISOR, {24'h0, d})
    standby <= 1'b1;
    `RDC(OFS_STATUS, 32'h84)
    `RDC(OFS_DIVISOR, 32'hff)
    standby <= 1'b0;
    wr(OFS_DIVISOR, 32'h0);
    // Generator reloads the new divisor only when its old count runs out
    repeat (260) @(posedge mclk);
    wr(OFS_STATUS, 32'hfd);
    `RDC(OFS_STATUS, 32'h85)
    wr(OFS_STATUS, 32'h0);
    `RDC(OFS_STATUS, 32'h84)
    // Transmit one character, end interrupt enabled after start
    d = 8'($urandom);
    wr(OFS_CONTROL, 32'h20);
    wr(OFS_TXDATA, {24'h0, d});
    `RDC(OFS_STATUS, 32'h84)
    wr(OFS_STATUS, 32'h7e);
    wr(OFS_CONTROL, 32'h24);
    `RDC(OFS_STATUS, 32'h80)
    n = 0;
    while (ssbr_peer_inst.got.size() == 0 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    `CHK(ssbr_peer_inst.got.size(), 1)
    rv = {24'h0, ssbr_peer_inst.got.pop_front()};
    `CHK(rv, {24'h0, d})
    n = 0;
    while (txEndIrq !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    `CHK(txEndIrq, 1'b1)
    `RDC(OFS_STATUS, 32'h84)
    // Receive path
    wr(OFS_CONTROL, 32'h10);
    c = 8'($urandom);
    ssbr_peer_inst.send(c, 1'b0, 1'b0, 1'b1);
    wr(OFS_STATUS, 32'h84);
    `RDC(OFS_STATUS, 32'hc4)
    `RDC(OFS_RXDATA, {24'h0, c})
    ssbr_peer_inst.send(~c, 1'b0, 1'b0, 1'b1);
    `RDC(OFS_STATUS, 32'he4)
    `RDC(OFS_RXDATA, {24'h0, c})
    wr(OFS_STATUS, 32'h9e);
    `RDC(OFS_STATUS, 32'h84)
    ssbr_peer_inst.send(c, 1'b0, 1'b0, 1'b0);
    `RDC(OFS_STATUS, 32'h94)
    wr(OFS_STATUS, 32'hee);
    wr(OFS_MODE, 32'h20);
    ssbr_peer_inst.send(c, 1'b1, ~^c, 1'b1);
    `RDC(OFS_STATUS, 32'h8c)
    wr(OFS_STATUS, 32'hf6);
    wr(OFS_MODE, 32'h04);
    ssbr_peer_inst.send(c, 1'b1, 1'b1, 1'b1);
    `RDC(OFS_STATUS, 32'hc6)
    wr(OFS_STATUS, 32'h0);
    `RDC(OFS_STATUS, 32'h86)
    wr(OFS_CONTROL, 32'h18);
    ssbr_peer_inst.send(~c, 1'b1, 1'b0, 1'b1);
    `RDC(OFS_STATUS, 32'h86)
    `RDC(OFS_RXDATA, {24'h0, c})
    ssbr_peer_inst.send(~c, 1'b1, 1'b1, 1'b1);
    `RDC(OFS_STATUS, 32'hc6)
    `RDC(OFS_CONTROL, 32'h10)
    `RDC(OFS_RXDATA, {24'h0, ~c})
    wr(OFS_CONTROL, 32'h0);
    ssbr_peer_inst.send(c, 1'b1, 1'b0, 1'b1);
    `RDC(OFS_STATUS, 32'hc6)
    complete_run;
  end
endmodule

// [verification/ssbr_peer.sv]
// Purpose: Remote serial peer sending and receiving async frames
// Assumes: One bit lasts BIT_CYC mclk cycles
// Notes: Line idles high between frames
`timescale 1ns/1ps
module ssbr_peer #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input wire logic mclk,
  // Serial lines
  input wire logic txd,
  input wire logic txdOe,
  output logic rxd
);
  logic [7:0] got[$];
  logic [7:0] b;
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Bit period matches the generator exactly
  task automatic send(input logic [7:0] d, input logic hasx, input logic x, input logic stopv);
    logic [10:0] f;
    int nb;
    f = hasx ? {stopv, x, d, 1'b0} : {1'b1, stopv, d, 1'b0};
    nb = hasx ? 11 : 10;
    @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= f[i];
      if (i == nb - 1 && !stopv) begin
        // Zero stop bit goes idle right after its mid-bit sample, else it reads as a new start
        repeat (BIT_CYC / 2 + 1) @(posedge mclk);
        rxd <= 1'b1;
        repeat (BIT_CYC / 2 - 1) @(posedge mclk);
      end else begin
        repeat (BIT_CYC) @(posedge mclk);
      end
    end
    rxd <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Receiver samples mid-bit
  initial forever begin
    @(posedge mclk);
    if (txdOe && txd === 1'b0) begin
      repeat (BIT_CYC + BIT_CYC / 2 - 1) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
        b[i] = txd;
        repeat (BIT_CYC) @(posedge mclk);
      end
      got.push_back(b);
    end
  end
endmodule
